// *** rtl/irt_device.sv ***
// Thermometer device end: result store, processing loop, rescale and pin mode switch
// Notes on behaviour
// - Rescale chosen temperature to 10-bit word
// - Object limits two cells, ambient one packed
// - Object 0.01 degC, ambient 0.64 degC counts
// - Subtract low, scale span over 1023
// - Object input 16-bit linear Kelvin scale
// - Ambient byte is (limit+38.2)*100/64
// - Host holds clock high during PWM
// - Request stops PWM, pin becomes SMBus data
// - Clock low over 1.44 ms, data ignored
// - PWM returns only after reset or wake
// - PWM off: SMBus straight after reset
// - Ambient at 006h, 0.02 K counts
// - Object MSB flags an error
// - Valid object 0000h to 7FFFh
// - Load calibration, then loop forever
// - Ambient steps in fixed order
// - Shared IR offset and gain stage
// - Object channels, second skipped if single
// - Refresh PWM data every loop pass
// - One FIR length, one IIR length
// - Config bit picks PWM, SMBus default
`timescale 1ns/1ps
module irt_device
  import irt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wake_pulse,
  input wire logic [WORD_W-1:0] amb_sample,
  input wire logic [WORD_W-1:0] obj1_sample,
  input wire logic [WORD_W-1:0] obj2_sample,
  output logic pwm_active,
  output logic [2:0] loop_step,
  irt_link_if.dev link
);
  import irt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [WORD_W-1:0] cfg_r, obj_low_r, obj_high_r, amb_range_r;
  logic [WORD_W-1:0] ambient_r, obj1_r, obj2_r, gain_r, offs_r;
  logic [CODE_W-1:0] pwm1_r, pwm2_r;
  logic pwm_en_r, pwm_valid_r;
  logic [WORD_W-1:0] rdata_r;
  logic rvalid_r;
  irt_loop_type st_r, st_nxt;
  logic [STEP_W-1:0] cnt_r;
  logic [3:0] phase_r;
  logic [2:0] scl_sync_r;
  logic scl_low_r;
  logic [REQ_CNT_W-1:0] req_cnt_r;

  // Cells take writes at once; the pulse enable follows them only at init or wake
  wire wr_cfg = link.bus_wr && link.bus_addr == REG_CONFIG;
  wire wr_low = link.bus_wr && link.bus_addr == REG_OBJ_LOW;
  wire wr_high = link.bus_wr && link.bus_addr == REG_OBJ_HIGH;
  wire wr_amb = link.bus_wr && link.bus_addr == REG_AMB_RANGE;

  ////////////////////////////////////////////////////////////////////////////
  // shared lengths
  wire [3:0] fir_len = cfg_r[CFG_FIR_LO +: 4];
  wire [3:0] iir_len = cfg_r[CFG_IIR_LO +: 4];
  wire [STEP_W-1:0] prog_steps = STEP_W'(fir_len) + STEP_W'(iir_len) + 8'h01;
  wire [STEP_W-1:0] fix_steps = STEP_W'(FIX_FIR_LEN);
  wire dual_ir = cfg_r[CFG_DUAL_IR];
  wire step_done = cnt_r == '0;
  wire last_phase = (st_r == ST_AMB) ? phase_r == 4'h5 :
                    (st_r == ST_IRCOM) ? phase_r == 4'h5 : phase_r == 4'h4;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_INIT: st_nxt = ST_AMB;
      ST_AMB: if (step_done && last_phase) st_nxt = ST_IRCOM;
      ST_IRCOM: if (step_done && last_phase) st_nxt = ST_OBJ1;
      ST_OBJ1: if (step_done && last_phase) st_nxt = dual_ir ? ST_OBJ2 : ST_PWM;
      ST_OBJ2: if (step_done && last_phase) st_nxt = ST_PWM;
      ST_PWM: st_nxt = ST_AMB;
      default: st_nxt = ST_INIT;
    endcase
  end

  // length chosen for the phase about to start, not the one ending
  function automatic logic prog_phase(input irt_loop_type st, input logic [3:0] ph);
    prog_phase = (st == ST_AMB && (ph == 4'h2 || ph == 4'h4)) ||
                 ((st == ST_OBJ1 || st == ST_OBJ2) && (ph == 4'h0 || ph == 4'h3));
  endfunction : prog_phase
  wire [STEP_W-1:0] next_len = prog_phase(st_r, phase_r + 4'h1) ? prog_steps : fix_steps;
  wire [STEP_W-1:0] entry_len = prog_phase(st_nxt, 4'h0) ? prog_steps : fix_steps;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_INIT;
      cnt_r <= '0;
      phase_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        phase_r <= '0;
        cnt_r <= entry_len;
      end else if (step_done) begin
        phase_r <= phase_r + 4'h1;
        cnt_r <= next_len;
      end else begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results: samples enter at the calculation phase of each stage
  wire amb_store = st_r == ST_AMB && step_done && phase_r == 4'h5;
  wire offs_store = st_r == ST_IRCOM && step_done && phase_r == 4'h1;
  wire gain_store = st_r == ST_IRCOM && step_done && phase_r == 4'h5;
  wire obj1_store = st_r == ST_OBJ1 && step_done && phase_r == 4'h4;
  wire obj2_store = st_r == ST_OBJ2 && step_done && phase_r == 4'h4;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ambient_r <= AMB_LOW_RAW;
      obj1_r <= '0;
      obj2_r <= '0;
      gain_r <= '0;
      offs_r <= '0;
    end else begin
      if (amb_store) ambient_r <= amb_sample;
      if (offs_store) offs_r <= obj1_sample;
      if (gain_store) gain_r <= obj2_sample;
      if (obj1_store) obj1_r <= obj1_sample;
      if (obj2_store) obj2_r <= obj2_sample;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ambient byte limits in raw counts
  wire [WORD_W-1:0] amb_lo = AMB_LOW_RAW + WORD_W'(amb_range_r[7:0]) * WORD_W'(AMB_LSB_RAW);
  wire [WORD_W-1:0] amb_hi_raw = AMB_LOW_RAW +
    WORD_W'(amb_range_r[AMB_HI_POS +: 8]) * WORD_W'(AMB_LSB_RAW);
  wire [WORD_W-1:0] amb_hi = (amb_hi_raw > AMB_HIGH_RAW) ? AMB_HIGH_RAW : amb_hi_raw;
  // object limits in 0.01 degC, results in 0.02 K: double the result
  wire [WORD_W-1:0] obj1_x2 = {obj1_r[WORD_W-2:0], 1'b0};
  wire [WORD_W-1:0] obj2_x2 = {obj2_r[WORD_W-2:0], 1'b0};
  wire obj1_err = obj1_r[OBJ_ERR_BIT];
  wire obj2_err = obj2_r[OBJ_ERR_BIT];
  wire [1:0] sel = cfg_r[CFG_SEL_LO +: 2];
  wire sel_amb = sel[1] == 1'b0;
  wire [WORD_W-1:0] src1 = sel_amb ? ambient_r : (sel == 2'b11 ? obj1_x2 : obj2_x2);
  wire [WORD_W-1:0] src2 = sel == 2'b00 ? obj1_x2 : obj2_x2;
  wire src1_err = !sel_amb && (sel == 2'b11 ? obj1_err : obj2_err);
  wire src2_err = sel == 2'b00 ? obj1_err : obj2_err;
  wire [CODE_W-1:0] code1, code2;

  irt_rescale u_rescale1 (
    .temp_in(src1),
    .range_low(sel_amb ? amb_lo : obj_low_r),
    .range_high(sel_amb ? amb_hi : obj_high_r),
    .code_out(code1)
  );
  irt_rescale u_rescale2 (
    .temp_in(src2),
    .range_low(obj_low_r),
    .range_high(obj_high_r),
    .code_out(code2)
  );

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm1_r <= '0;
      pwm2_r <= '0;
      pwm_valid_r <= 1'b0;
    end else if (st_r == ST_PWM) begin
      pwm1_r <= src1_err ? CODE_MAX : code1;
      pwm2_r <= src2_err ? CODE_MAX : code2;
      pwm_valid_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock low detector, data level ignored
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync_r <= 3'h7;
      scl_low_r <= 1'b0;
      req_cnt_r <= '0;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], link.scl};
      if (scl_sync_r[1] == scl_sync_r[2]) scl_low_r <= !scl_sync_r[2];
      if (!scl_low_r) req_cnt_r <= '0;
      else if (req_cnt_r != REQ_CNT_W'(REQ_CYCLES)) req_cnt_r <= req_cnt_r + 16'h0001;
    end
  end
  wire req_seen = req_cnt_r == REQ_CNT_W'(REQ_CYCLES);

  // Config latched once the init step runs, so a later write needs a wake to act
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pwm_en_r <= 1'b0;
    end else if (st_r == ST_INIT || wake_pulse) begin
      // config bit, re-enable on wake, off means SMBus
      pwm_en_r <= cfg_r[CFG_PWM_EN];
    end else if (req_seen) begin
      pwm_en_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // config and range cells, limits held in document granularity, not raw counts
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= CFG_RESET;
      obj_low_r <= OBJ_LOW_RESET;
      obj_high_r <= OBJ_HIGH_RESET;
      amb_range_r <= AMB_RANGE_RESET;
    end else begin
      if (wr_cfg) cfg_r <= link.bus_wdata;
      if (wr_low) obj_low_r <= link.bus_wdata;
      if (wr_high) obj_high_r <= link.bus_wdata;
      if (wr_amb) amb_range_r <= link.bus_wdata;
    end
  end

  wire [WORD_W-1:0] rd_mux =
    link.bus_addr == REG_CONFIG ? cfg_r :
    link.bus_addr == REG_OBJ_LOW ? obj_low_r :
    link.bus_addr == REG_OBJ_HIGH ? obj_high_r :
    link.bus_addr == REG_AMB_RANGE ? amb_range_r :
    link.bus_addr == REG_AMBIENT ? ambient_r :
    link.bus_addr == REG_OBJ1 ? obj1_r :
    link.bus_addr == REG_OBJ2 ? obj2_r :
    link.bus_addr == REG_PWM1 ? {6'h00, pwm1_r} :
    link.bus_addr == REG_PWM2 ? {6'h00, pwm2_r} :
    link.bus_addr == REG_STATUS ? {12'h000, pwm_en_r, st_r} : 16'h0000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= link.bus_rd;
      if (link.bus_rd) rdata_r <= rd_mux;
    end
  end

  // PWM drives the pin only while enabled; pin released otherwise
  assign link.sda_dev_o = pwm1_r[CODE_W-1];
  assign link.sda_dev_oe_n = !pwm_en_r;
  assign link.pwm_valid = pwm_valid_r && pwm_en_r;
  assign link.pwm1 = pwm1_r;
  assign link.pwm2 = pwm2_r;
  assign link.bus_rdata = rdata_r;
  assign link.bus_rvalid = rvalid_r;
  assign pwm_active = pwm_en_r;
  assign loop_step = st_r;
endmodule : irt_device

// *** rtl/irt_host.sv ***
// Host end: issues the switch request, then passes register traffic
`timescale 1ns/1ps
module irt_host
  import irt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  irt_link_if.host link
);
  import irt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  irt_host_type st_r, st_nxt;
  logic [REQ_CNT_W-1:0] cnt_r;
  logic [7:0] addr_r;
  logic [15:0] wdata_r, rd_r, sw_rdata_r;
  logic bus_wr_r, bus_rd_r, busy_r;
  logic [9:0] pwm_cap_r;

  wire ctrl_wr = sw_wr && sw_addr == HR_CTRL;
  wire start_req = ctrl_wr && sw_wdata[HC_REQ];
  wire req_done = cnt_r == REQ_CNT_W'(REQ_CYCLES + HOLD_EXTRA);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HS_IDLE: if (start_req) st_nxt = HS_REQ;
      // hold clock low past the request time
      HS_REQ: if (req_done) st_nxt = HS_BUS;
      HS_BUS: st_nxt = HS_BUS;
      default: st_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= HS_IDLE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_r == HS_REQ) ? cnt_r + 16'h0001 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus traffic in idle or after request, none while clock held low; software skips request when PWM off
  wire bus_ok = st_r == HS_BUS || (st_r == HS_IDLE && sw_wdata[HC_REQ] == 1'b0);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= '0;
      wdata_r <= '0;
      bus_wr_r <= 1'b0;
      bus_rd_r <= 1'b0;
      rd_r <= '0;
      busy_r <= 1'b0;
      pwm_cap_r <= '0;
    end else begin
      if (sw_wr && sw_addr == HR_ADDR) addr_r <= sw_wdata[7:0];
      if (sw_wr && sw_addr == HR_WDATA) wdata_r <= sw_wdata;
      bus_wr_r <= ctrl_wr && sw_wdata[HC_WR] && bus_ok;
      bus_rd_r <= ctrl_wr && sw_wdata[HC_RD] && !sw_wdata[HC_WR] && bus_ok;
      busy_r <= bus_rd_r;
      if (link.bus_rvalid) rd_r <= link.bus_rdata;
      if (link.pwm_valid) pwm_cap_r <= link.pwm1;
    end
  end

  wire [15:0] rd_mux =
    sw_addr == HR_CTRL ? 16'h0000 :
    sw_addr == HR_ADDR ? {8'h00, addr_r} :
    sw_addr == HR_WDATA ? wdata_r :
    sw_addr == HR_RDATA ? rd_r :
    sw_addr == HR_STATUS ? {13'h0000, busy_r, st_r} :
    sw_addr == HR_PWM ? {6'h00, pwm_cap_r} : 16'h0000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) sw_rdata_r <= '0;
    else if (sw_rd) sw_rdata_r <= rd_mux;
  end

  assign link.scl = st_r != HS_REQ;
  assign link.sda_host_o = 1'b1;
  assign link.sda_host_oe_n = 1'b1;
  assign link.bus_wr = bus_wr_r;
  assign link.bus_rd = bus_rd_r;
  assign link.bus_addr = addr_r;
  assign link.bus_wdata = wdata_r;
  assign sw_rdata = sw_rdata_r;
endmodule : irt_host

// *** rtl/irt_link_if.sv ***
// Link between thermometer and its host: clock line, shared data/PWM pin, register port
`timescale 1ns/1ps
interface irt_link_if;
  logic scl;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic pwm_valid;
  logic [9:0] pwm1;
  logic [9:0] pwm2;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_addr;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic bus_rvalid;
  wire sda_line;
  assign sda_line = (!sda_dev_oe_n && !sda_dev_o) || (!sda_host_oe_n && !sda_host_o) ? 1'b0 : 1'b1;
  modport dev (input scl, output sda_dev_o, output sda_dev_oe_n, input sda_line,
    output pwm_valid, output pwm1, output pwm2, input bus_wr, input bus_rd,
    input bus_addr, input bus_wdata, output bus_rdata, output bus_rvalid);
  modport host (output scl, output sda_host_o, output sda_host_oe_n, input sda_line,
    input pwm_valid, input pwm1, input pwm2, output bus_wr, output bus_rd,
    output bus_addr, output bus_wdata, input bus_rdata, input bus_rvalid);
endinterface : irt_link_if

// *** rtl/irt_pkg.sv ***
// Shared constants and types for the thermometer readout link
package irt_pkg;
  // Clock and request timing
  localparam int CLK_HZ = 20000000;
  localparam int REQ_TIME_US = 1440;
  localparam longint REQ_CYCLES_L = (longint'(REQ_TIME_US) * CLK_HZ + 999999) / 1000000;
  localparam int REQ_CYCLES = int'(REQ_CYCLES_L);
  localparam int REQ_CNT_W = 16;
  localparam int HOLD_EXTRA = 20;
  // Data widths
  localparam int WORD_W = 16;
  localparam int CODE_W = 10;
  localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
  localparam logic [CODE_W-1:0] CODE_MIN = 10'h000;
  localparam logic [10:0] SPAN_STEPS = 11'h3FF;
  // Result encodings
  localparam logic [WORD_W-1:0] AMB_LOW_RAW = 16'h2DE4;
  localparam logic [WORD_W-1:0] AMB_HIGH_RAW = 16'h4DC4;
  localparam int OBJ_ERR_BIT = 15;
  localparam logic [WORD_W-1:0] OBJ_VALID_MAX = 16'h7FFF;
  // Ambient range byte: one count of 0.64 degC is 32 counts of 0.02 K
  localparam int AMB_LSB_RAW = 32;
  localparam int AMB_HI_POS = 8;
  // Device register indices
  localparam logic [7:0] REG_OBJ_HIGH = 8'h00;
  localparam logic [7:0] REG_OBJ_LOW = 8'h01;
  localparam logic [7:0] REG_CONFIG = 8'h02;
  localparam logic [7:0] REG_AMB_RANGE = 8'h03;
  localparam logic [7:0] REG_AMBIENT = 8'h06;
  localparam logic [7:0] REG_OBJ1 = 8'h07;
  localparam logic [7:0] REG_OBJ2 = 8'h08;
  localparam logic [7:0] REG_PWM1 = 8'h09;
  localparam logic [7:0] REG_PWM2 = 8'h0A;
  localparam logic [7:0] REG_STATUS = 8'h0B;
  // Config field positions
  localparam int CFG_PWM_EN = 0;
  localparam int CFG_DUAL_IR = 1;
  localparam int CFG_SEL_LO = 4;
  localparam int CFG_FIR_LO = 8;
  localparam int CFG_IIR_LO = 12;
  // Reset values (SMBus default, single sensor)
  localparam logic [WORD_W-1:0] CFG_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] OBJ_LOW_RESET = 16'h6AB3;
  localparam logic [WORD_W-1:0] OBJ_HIGH_RESET = 16'h7E3B;
  localparam logic [WORD_W-1:0] AMB_RANGE_RESET = 16'hFF00;
  localparam int FIX_FIR_LEN = 8;
  localparam int STEP_W = 8;
  // Host controller register offsets
  localparam logic [3:0] HR_CTRL = 4'h0;
  localparam logic [3:0] HR_ADDR = 4'h1;
  localparam logic [3:0] HR_WDATA = 4'h2;
  localparam logic [3:0] HR_RDATA = 4'h3;
  localparam logic [3:0] HR_STATUS = 4'h4;
  localparam logic [3:0] HR_PWM = 4'h5;
  localparam int HC_REQ = 0;
  localparam int HC_WR = 1;
  localparam int HC_RD = 2;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_AMB = 3'b001,
    ST_IRCOM = 3'b011,
    ST_OBJ1 = 3'b010,
    ST_OBJ2 = 3'b110,
    ST_PWM = 3'b111
  } irt_loop_type;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_REQ = 2'b01,
    HS_BUS = 2'b11
  } irt_host_type;
endpackage : irt_pkg

// *** rtl/irt_rescale.sv ***
// Rescales a 16-bit temperature into a clamped 10-bit output code
`timescale 1ns/1ps
module irt_rescale
  import irt_pkg::*;
(
  input wire logic [WORD_W-1:0] temp_in,
  input wire logic [WORD_W-1:0] range_low,
  input wire logic [WORD_W-1:0] range_high,
  output logic [CODE_W-1:0] code_out
);
  import irt_pkg::*;
  wire [WORD_W:0] span = {1'b0, range_high} - {1'b0, range_low};
  wire [WORD_W:0] offs = {1'b0, temp_in} - {1'b0, range_low};
  wire below = temp_in < range_low;
  wire above = temp_in >= range_high;
  // Code = offs*1023/span keeps full precision instead of dividing by a rounded step
  wire [27:0] prod = 28'(offs) * 28'(SPAN_STEPS);
  wire [27:0] quot = (span == '0) ? 28'h0000000 : prod / 28'(span);
  assign code_out = below ? CODE_MIN : above ? CODE_MAX : quot[CODE_W-1:0];
endmodule : irt_rescale

// *** verif/irt_link_sva.sv ***
// Concurrent checks on the link between the thermometer and its host
`timescale 1ns/1ps
module irt_link_sva
  import irt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe_n,
  input wire logic sda_host_oe_n,
  input wire logic sda_line,
  input wire logic pwm_valid,
  input wire logic [9:0] pwm1,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_rvalid
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  // Length of the latest low stretch on the clock line, held once it ends,
  // so the release check can still read it once the line has gone high again
  logic scl_r;
  logic [15:0] low_run_r;
  logic [15:0] low_run_nxt;
  assign low_run_nxt = !scl ? (scl_r ? 16'h0001 : low_run_r + 16'h0001) : low_run_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_r <= 1'b1;
      low_run_r <= 16'h0000;
    end else begin
      scl_r <= scl;
      low_run_r <= low_run_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_reset_serial: assert property ($rose(reset_n) |-> sda_dev_oe_n [*4])
    else $error("pin driven right after reset");
  a_host_sda_free: assert property (sda_host_oe_n)
    else $error("host drives the data line");
  a_read_answer: assert property (bus_rd |=> bus_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (bus_rvalid |-> $past(bus_rd))
    else $error("read valid without a read");
  a_strobe_excl: assert property (!(bus_wr && bus_rd))
    else $error("read and write strobes together");
  a_quiet_request: assert property (!scl |-> !bus_wr && !bus_rd)
    else $error("bus traffic while clock held low");
  a_req_length: assert property ($rose(sda_dev_oe_n) |-> low_run_r >= REQ_CYCLES)
    else $error("pin released after a short low");
  a_req_release: assert property ($rose(scl) && low_run_r >= REQ_CYCLES |-> ##[0:40] sda_dev_oe_n)
    else $error("long low did not release the pin");
  a_stays_serial: assert property ($rose(sda_dev_oe_n) |=> sda_dev_oe_n [*8])
    else $error("pulse output came back");
  a_pin_code: assert property (!sda_dev_oe_n |-> sda_line == pwm1[9])
    else $error("pin does not show the code");
  a_valid_pin: assert property ($fell(sda_dev_oe_n) |-> ##[0:1000] pwm_valid)
    else $error("no code loaded after pulse output began");
  c_request: cover property ($rose(sda_dev_oe_n));
  c_pwm_on: cover property ($fell(sda_dev_oe_n));
  c_read: cover property (bus_rd ##1 bus_rvalid);
endmodule : irt_link_sva

// *** verif/tb.sv ***
// Testbench joining the thermometer end and the host end
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("Error %s expected %h got %h", nm, exp, got); end end
module tb;
  import irt_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic wake_pulse = 1'b0;
  logic [15:0] amb_sample = 16'h2DE4;
  logic [15:0] obj1_sample = 16'h0100;
  logic [15:0] obj2_sample = 16'h0200;
  logic pwm_active;
  logic [2:0] loop_step;
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic seen_zone2 = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  irt_link_if lnk();
  irt_device irt_device_inst(.clk_sys(clk_sys), .reset_n(reset_n), .wake_pulse(wake_pulse),
    .amb_sample(amb_sample), .obj1_sample(obj1_sample), .obj2_sample(obj2_sample),
    .pwm_active(pwm_active), .loop_step(loop_step), .link(lnk.dev));
  irt_host irt_host_inst(.clk_sys(clk_sys), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(lnk.host));
  irt_link_sva irt_link_sva_inst(.clk_sys(clk_sys), .reset_n(reset_n), .scl(lnk.scl),
    .sda_dev_o(lnk.sda_dev_o), .sda_dev_oe_n(lnk.sda_dev_oe_n),
    .sda_host_oe_n(lnk.sda_host_oe_n), .sda_line(lnk.sda_line), .pwm_valid(lnk.pwm_valid),
    .pwm1(lnk.pwm1), .bus_wr(lnk.bus_wr), .bus_rd(lnk.bus_rd), .bus_rvalid(lnk.bus_rvalid));
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (loop_step === 3'b110) seen_zone2 <= 1'b1;
  ////////////////////////////////////////////////////////////////
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    @(negedge clk_sys);
    d = sw_rdata;
  endtask : sw_read
  task automatic dev_write(input logic [7:0] idx, input logic [15:0] d);
    sw_write(HR_ADDR, {8'h00, idx});
    sw_write(HR_WDATA, d);
    sw_write(HR_CTRL, 16'h0002);
    repeat (4) @(posedge clk_sys);
  endtask : dev_write
  // Device read lands in the host's data register a few cycles after the order
  task automatic check_reg(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    sw_write(HR_ADDR, {8'h00, idx});
    sw_write(HR_CTRL, 16'h0004);
    repeat (4) @(posedge clk_sys);
    sw_read(HR_RDATA, d);
    `CHK("device register", exp, d)
  endtask : check_reg
  task automatic wake_up();
    @(posedge clk_sys);
    wake_pulse <= 1'b1;
    @(posedge clk_sys);
    wake_pulse <= 1'b0;
  endtask : wake_up
  task automatic wait_pass(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (loop_step !== 3'b111 && k < 20000) begin
        @(posedge clk_sys);
        k++;
      end
      while (loop_step === 3'b111 && k < 20000) begin
        @(posedge clk_sys);
        k++;
      end
      if (k >= 20000) `CHK("loop pass", 1'b1, 1'b0)
    end
  endtask : wait_pass
  ////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    `CHK("pwm_active", 1'b0, pwm_active)
    `CHK("pin enable", 1'b1, lnk.sda_dev_oe_n)
    wait_pass(1);
    check_reg(REG_OBJ_HIGH, 16'h7E3B);
    check_reg(REG_OBJ_LOW, 16'h6AB3);
    check_reg(REG_CONFIG, 16'h0000);
    check_reg(REG_AMB_RANGE, 16'hFF00);
    dev_write(REG_AMBIENT, 16'h1234);
    check_reg(REG_AMBIENT, 16'h2DE4);
    check_reg(REG_OBJ1, 16'h0100);
    dev_write(8'h05, 16'hBEEF);
    check_reg(8'h05, 16'h0000);
    $display("test reset_values done");
  endtask : t_reset_values
  // Limits chosen so that an object count r gives the code r - 10h exactly
  task automatic t_pwm_modes();
    logic [15:0] cfg [4] = '{16'h0003, 16'h0013, 16'h0023, 16'h0033};
    logic [9:0] e1 [4] = '{10'h3FF, 10'h3FF, 10'h1F0, 10'h0F0};
    logic [9:0] e2 [4] = '{10'h0F0, 10'h1F0, 10'h000, 10'h1F0};
    logic [15:0] d;
    dev_write(REG_OBJ_LOW, 16'h0020);
    dev_write(REG_OBJ_HIGH, 16'h081E);
    amb_sample <= 16'h4DC4;
    for (int i = 0; i < 4; i++) begin
      dev_write(REG_CONFIG, cfg[i]);
      wake_up();
      seen_zone2 <= 1'b0;
      wait_pass(2);
      `CHK("pwm_active", 1'b1, pwm_active)
      `CHK("pwm1", e1[i], lnk.pwm1)
      if (i != 2) `CHK("pwm2", e2[i], lnk.pwm2)
      `CHK("zone2 step", 1'b1, seen_zone2)
      sw_read(HR_PWM, d);
      `CHK("host pwm capture", 16'(e1[i]), d)
    end
    $display("test pwm_modes done");
  endtask : t_pwm_modes
  task automatic t_clamp();
    obj1_sample <= 16'h0008;
    obj2_sample <= 16'h0500;
    wait_pass(2);
    `CHK("pwm1 low clamp", 10'h000, lnk.pwm1)
    `CHK("pwm2 high clamp", 10'h3FF, lnk.pwm2)
    obj1_sample <= 16'h8100;
    obj2_sample <= 16'h7FFF;
    wait_pass(2);
    `CHK("pwm1 error flag", 10'h3FF, lnk.pwm1)
    `CHK("pwm2 top value", 10'h3FF, lnk.pwm2)
    dev_write(REG_AMB_RANGE, 16'h993C);
    dev_write(REG_CONFIG, 16'h0003);
    wake_up();
    amb_sample <= 16'h3564;
    wait_pass(2);
    `CHK("ambient low", 10'h000, lnk.pwm1)
    amb_sample <= 16'h3B24;
    wait_pass(2);
    `CHK("ambient mid", 10'h1FA, lnk.pwm1)
    amb_sample <= 16'h4104;
    wait_pass(2);
    `CHK("ambient high", 10'h3FF, lnk.pwm1)
    $display("test clamp done");
  endtask : t_clamp
  task automatic t_single();
    dev_write(REG_CONFIG, 16'h2101);
    wake_up();
    wait_pass(1);
    seen_zone2 <= 1'b0;
    wait_pass(2);
    `CHK("zone2 skipped", 1'b0, seen_zone2)
    `CHK("pwm_active", 1'b1, pwm_active)
    $display("test single done");
  endtask : t_single
  task automatic t_request();
    int k;
    logic [15:0] d;
    k = 0;
    sw_write(HR_CTRL, 16'h0001);
    repeat (100) @(posedge clk_sys);
    `CHK("scl held low", 1'b0, lnk.scl)
    while (pwm_active !== 1'b0 && k < 30000) begin
      @(posedge clk_sys);
      k++;
    end
    `CHK("request span", 1'b1, (k + 100 >= REQ_CYCLES && k < 30000))
    `CHK("pin released", 1'b1, lnk.sda_dev_oe_n)
    repeat (40) @(posedge clk_sys);
    wait_pass(2);
    `CHK("pwm stays off", 1'b0, pwm_active)
    check_reg(REG_OBJ_LOW, 16'h0020);
    sw_read(HR_STATUS, d);
    `CHK("host state", 16'(HS_BUS), d)
    wake_up();
    wait_pass(1);
    `CHK("pwm after wake", 1'b1, pwm_active)
    $display("test request done");
  endtask : t_request
  task automatic t_rereset();
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    `CHK("pwm_active", 1'b0, pwm_active)
    check_reg(REG_CONFIG, 16'h0000);
    $display("test rereset done");
  endtask : t_rereset
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset_values();
    t_pwm_modes();
    t_clamp();
    t_single();
    t_request();
    t_rereset();
    wrap_up();
  end
  // Whole run is some tens of thousands of cycles, dominated by the request
  initial begin
    #(60000 * 50);
    fail_count++;
    $display("Error watchdog expected finish got hang");
    wrap_up();
  end
endmodule : tb
